// *** include/gsr_pkg.sv ***
package gsr_pkg;
	// sequencer runs on the input clock divided by this
	localparam int SEQ_DIV = 4;
	// overhead times in input clock periods, sequencer sees them in ticks
	localparam int FOT_CLOCKS = 624;
	localparam int ROT_CLOCKS = 32;
	localparam int FOT_TICKS = FOT_CLOCKS / SEQ_DIV;
	localparam int ROT_TICKS = ROT_CLOCKS / SEQ_DIV;
	// register port
	localparam int AW = 8;
	localparam int DW = 16;
	localparam logic [AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AW-1:0] REG_LINES = 8'h04;
	localparam logic [AW-1:0] REG_PIXELS = 8'h08;
	localparam logic [AW-1:0] REG_INTEG = 8'h0c;
	localparam logic [AW-1:0] REG_DUAL = 8'h10;
	localparam logic [AW-1:0] REG_TRIPLE = 8'h14;
	localparam logic [AW-1:0] REG_STATUS = 8'h18;
	// control bits
	localparam int CTRL_INTERNAL = 0;
	localparam int CTRL_OVERLAP = 1;
	localparam int CTRL_REPEAT = 2;
	localparam int CTRL_DUAL = 3;
	localparam int CTRL_TRIPLE = 4;
	localparam int CTRL_RUN = 5;
	// status bits
	localparam int STAT_FRAME = 0;
	localparam int STAT_QUAL = 1;
	localparam int STAT_INTEG = 2;
	localparam int STAT_REPEAT = 3;
	localparam int STAT_INTERNAL = 4;
	localparam int STAT_READING = 5;
	// reset values
	localparam logic [DW-1:0] CTRL_RESET = 16'h0001;
	localparam logic [DW-1:0] LINES_RESET = 16'h01e0;
	localparam logic [DW-1:0] PIXELS_RESET = 16'h0280;
	localparam logic [DW-1:0] INTEG_RESET = 16'h0100;
	localparam logic [DW-1:0] DUAL_RESET = 16'h0040;
	localparam logic [DW-1:0] TRIPLE_RESET = 16'h0010;
	// serial frame: read flag, 4 index bits, 16 data bits
	localparam int SPI_CMD_BITS = 5;
	localparam int SPI_DATA_BITS = 16;
	localparam logic [4:0] SPI_CMD_LAST = 5'h04;
	localparam logic [4:0] SPI_FRAME_LAST = 5'h14;
	typedef enum logic [2:0] {
		INT_IDLE, INT_RESET, INT_EXPOSE, INT_HOLD, INT_XFER
	} gsr_int_e;
	typedef enum logic [1:0] {RD_IDLE, RD_FOT, RD_ROT, RD_PIX} gsr_rd_e;
endpackage

// *** verilog/gsr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module gsr_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// *** verilog/gsr_spi_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module gsr_spi_slave import gsr_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// synchronised serial pins
	input wire logic en_s,
	input wire logic sclk_s,
	input wire logic sdi_s,
	// serial data line drive
	output logic line_out,
	output logic line_oe,
	// register access
	output logic wr,
	output logic rd,
	output logic [AW-1:0] addr,
	output logic [DW-1:0] wdata,
	input wire logic [DW-1:0] rdata
);
	logic sclk_q;
	logic rise;
	logic [4:0] bit_cnt;
	logic [DW-1:0] shin;
	logic [DW-1:0] shout;
	logic is_read;
	logic rd_q;
	logic rd_q2;

	assign rise = sclk_s & ~sclk_q;
	assign line_out = shout[DW-1];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk_s;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit_cnt <= 5'h00;
			shin <= '0;
			is_read <= 1'b0;
			wr <= 1'b0;
			rd <= 1'b0;
			addr <= '0;
			wdata <= '0;
		end else begin
			wr <= 1'b0;
			rd <= 1'b0;
			if (!en_s) begin
				bit_cnt <= 5'h00;
				is_read <= 1'b0;
			end else if (rise && bit_cnt <= SPI_FRAME_LAST) begin
				shin <= {shin[DW-2:0], sdi_s};
				bit_cnt <= bit_cnt + 5'h01;
				if (bit_cnt == SPI_CMD_LAST) begin
					is_read <= shin[3];
					addr <= {2'b00, shin[2:0], sdi_s, 2'b00};
					rd <= shin[3];
				end
				if (bit_cnt == SPI_FRAME_LAST && !is_read) begin
					wr <= 1'b1;
					wdata <= {shin[DW-2:0], sdi_s};
				end
			end
		end
	end

	// line is driven only in the data phase of a read, never in the
	// command phase, so the two ends never fight
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_q <= 1'b0;
			rd_q2 <= 1'b0;
			shout <= '0;
			line_oe <= 1'b0;
		end else begin
			rd_q <= rd;
			rd_q2 <= rd_q;
			if (!en_s || (rise && bit_cnt > SPI_FRAME_LAST)) begin
				line_oe <= 1'b0;
			end else if (rd_q2) begin
				shout <= rdata;
				line_oe <= 1'b1;
			end else if (rise && line_oe && bit_cnt > SPI_CMD_LAST) begin
				shout <= {shout[DW-2:0], 1'b0};
			end
		end
	end
endmodule
`default_nettype wire

// *** verilog/gsr_readout_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module gsr_readout_ctrl import gsr_pkg::*; #(
	parameter int PIX_W = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata,
	// sequencer reset pin
	input wire logic sequencer_reset_low,
	// exposure windows: bit 0 primary, 1 second, 2 third
	input wire logic [2:0] exposure_window_in,
	output logic [2:0] exposure_window_out,
	output logic [2:0] exposure_window_oe,
	// serial configuration pins
	input wire logic serial_port_enable,
	input wire logic serial_port_clock,
	input wire logic serial_port_line_in,
	output logic serial_port_line_out,
	output logic serial_port_line_oe,
	// pixel array control
	output logic array_reset,
	output logic array_transfer,
	output logic [2:0] array_window,
	output logic [DW-1:0] row_index,
	output logic [DW-1:0] col_index,
	// converter data in, pixel stream out
	input wire logic [PIX_W-1:0] converter_data,
	output logic [PIX_W-1:0] pixel_data,
	output logic row_data_qualifier,
	output logic image_period_flag
);
	generate
		if (PIX_W < 1 || PIX_W > DW) begin : g_bad_width
			$error("PIX_W must lie between 1 and DW");
		end
	endgenerate

	logic [6:0] pins_s;
	logic seq_run;
	logic [2:0] ew_s;
	logic spi_en_s;
	logic spi_clk_s;
	logic spi_dat_s;
	logic [1:0] div_cnt;
	logic tick;
	logic [DW-1:0] ctrl;
	logic [DW-1:0] lines;
	logic [DW-1:0] pixels;
	logic [DW-1:0] integ;
	logic [DW-1:0] dual;
	logic [DW-1:0] triple;
	logic [DW-1:0] act_lines;
	logic [DW-1:0] act_pixels;
	logic act_repeat;
	logic act_internal;
	logic reset_done;
	logic spi_wr;
	logic spi_rd;
	logic [AW-1:0] spi_addr;
	logic [DW-1:0] spi_wdata;
	logic [DW-1:0] spi_rdata;
	logic wr_any;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	gsr_int_e int_st;
	gsr_int_e next_int_st;
	gsr_rd_e rd_st;
	gsr_rd_e next_rd_st;
	logic [DW-1:0] int_cnt;
	logic [DW-1:0] rd_cnt;
	logic expose_done;
	logic [2:0] int_win;
	logic rd_start;

	// pins from outside the clock domain
	gsr_sync #(.W(7)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({serial_port_line_in, serial_port_clock, serial_port_enable,
			exposure_window_in, sequencer_reset_low}),
		.q(pins_s)
	);
	assign seq_run = pins_s[0];
	assign ew_s = pins_s[3:1];
	assign spi_en_s = pins_s[4];
	assign spi_clk_s = pins_s[5];
	assign spi_dat_s = pins_s[6];

	gsr_spi_slave u_spi (
		.clk(clk),
		.rst_n(rst_n),
		.en_s(spi_en_s),
		.sclk_s(spi_clk_s),
		.sdi_s(spi_dat_s),
		.line_out(serial_port_line_out),
		.line_oe(serial_port_line_oe),
		.wr(spi_wr),
		.rd(spi_rd),
		.addr(spi_addr),
		.wdata(spi_wdata),
		.rdata(spi_rdata)
	);

	// sequencer tick at a quarter of clk
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end
	assign tick = (div_cnt == 2'(SEQ_DIV - 1));

	function automatic logic [DW-1:0] reg_value(input logic [AW-1:0] a);
		logic [DW-1:0] v;
		v = '0;
		unique case (a)
			REG_CTRL: v = ctrl;
			REG_LINES: v = lines;
			REG_PIXELS: v = pixels;
			REG_INTEG: v = integ;
			REG_DUAL: v = dual;
			REG_TRIPLE: v = triple;
			REG_STATUS: begin
				v[STAT_FRAME] = image_period_flag;
				v[STAT_QUAL] = row_data_qualifier;
				v[STAT_INTEG] = (int_st != INT_IDLE);
				v[STAT_REPEAT] = act_repeat;
				v[STAT_INTERNAL] = act_internal;
				v[STAT_READING] = (rd_st != RD_IDLE);
			end
			default: v = '0;
		endcase
		return v;
	endfunction

	// port write wins a same-cycle collision with a serial write
	assign wr_any = reg_wr | spi_wr;
	assign waddr = reg_wr ? reg_addr : spi_addr;
	assign wdata = reg_wr ? reg_wdata : spi_wdata;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl <= CTRL_RESET;
			lines <= LINES_RESET;
			pixels <= PIXELS_RESET;
			integ <= INTEG_RESET;
			dual <= DUAL_RESET;
			triple <= TRIPLE_RESET;
		end else if (wr_any) begin
			unique case (waddr)
				REG_CTRL: ctrl <= wdata;
				REG_LINES: lines <= wdata;
				REG_PIXELS: pixels <= wdata;
				REG_INTEG: integ <= wdata;
				REG_DUAL: dual <= wdata;
				REG_TRIPLE: triple <= wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
			spi_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? reg_value(reg_addr) : '0;
			if (spi_rd) begin
				spi_rdata <= reg_value(spi_addr);
			end
		end
	end

	// frame geometry and repeat mode take effect only while the frame
	// flag is low, so a frame never changes shape mid-readout
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			act_lines <= LINES_RESET;
			act_pixels <= PIXELS_RESET;
			act_repeat <= 1'b0;
		end else if (rd_st == RD_IDLE || rd_st == RD_FOT) begin
			act_lines <= lines;
			act_pixels <= pixels;
			act_repeat <= ctrl[CTRL_REPEAT];
		end
	end

	// mode may only flip between integrations
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			act_internal <= 1'b1;
		end else if (int_st == INT_IDLE) begin
			act_internal <= ctrl[CTRL_INTERNAL];
		end
	end

	// integration sequencer
	assign expose_done = act_internal ?
		({1'b0, int_cnt} + 17'h00001 >= {1'b0, integ}) :
		!ew_s[0];

	always_comb begin
		next_int_st = int_st;
		unique case (int_st)
			INT_IDLE: begin
				// sequential mode waits for the previous readout
				if (ctrl[CTRL_RUN] &&
					(ctrl[CTRL_OVERLAP] || rd_st == RD_IDLE) &&
					(act_internal || ew_s[0])) begin
					next_int_st = INT_RESET;
				end
			end
			INT_RESET: next_int_st = INT_EXPOSE;
			INT_EXPOSE: begin
				if (expose_done) begin
					next_int_st = INT_HOLD;
				end
			end
			// storage nodes are busy until readout is finished
			INT_HOLD: begin
				if (rd_st == RD_IDLE) begin
					next_int_st = INT_XFER;
				end
			end
			INT_XFER: next_int_st = INT_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !seq_run) begin
			int_st <= INT_IDLE;
			int_cnt <= '0;
			array_reset <= 1'b0;
			array_transfer <= 1'b0;
		end else if (tick) begin
			int_st <= next_int_st;
			int_cnt <= (int_st == INT_EXPOSE) ? int_cnt + 16'h0001 : '0;
			// repeat read skips every reset after the first
			array_reset <= next_int_st == INT_RESET &&
				!(act_repeat && reset_done);
			array_transfer <= (next_int_st == INT_XFER);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !seq_run) begin
			reset_done <= 1'b0;
		end else if (!act_repeat) begin
			reset_done <= 1'b0;
		end else if (tick && int_st == INT_RESET) begin
			reset_done <= 1'b1;
		end
	end

	// slope windows sit at the end of integration
	always_comb begin
		int_win[0] = (int_st == INT_EXPOSE);
		int_win[1] = int_win[0] && ctrl[CTRL_DUAL] &&
			({1'b0, int_cnt} + {1'b0, dual} >= {1'b0, integ});
		int_win[2] = int_win[0] && ctrl[CTRL_TRIPLE] &&
			({1'b0, int_cnt} + {1'b0, triple} >= {1'b0, integ});
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			exposure_window_out <= 3'h0;
			exposure_window_oe <= 3'h0;
			array_window <= 3'h0;
		end else begin
			exposure_window_out <= act_internal ? int_win : 3'h0;
			exposure_window_oe <= {3{act_internal}};
			array_window <= act_internal ? int_win : ew_s;
		end
	end

	// readout sequencer
	assign rd_start = (int_st == INT_XFER);

	always_comb begin
		next_rd_st = rd_st;
		unique case (rd_st)
			RD_IDLE: begin
				if (rd_start) begin
					next_rd_st = RD_FOT;
				end
			end
			RD_FOT: begin
				if (rd_cnt == DW'(FOT_TICKS - 1)) begin
					next_rd_st = RD_ROT;
				end
			end
			RD_ROT: begin
				if (rd_cnt == DW'(ROT_TICKS - 1)) begin
					next_rd_st = RD_PIX;
				end
			end
			RD_PIX: begin
				if (col_index + 16'h0001 >= act_pixels) begin
					if (row_index + 16'h0001 >= act_lines) begin
						next_rd_st = RD_IDLE;
					end else begin
						next_rd_st = RD_ROT;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !seq_run) begin
			rd_st <= RD_IDLE;
			rd_cnt <= '0;
			row_index <= '0;
			col_index <= '0;
		end else if (tick) begin
			rd_st <= next_rd_st;
			rd_cnt <= (next_rd_st == rd_st) ? rd_cnt + 16'h0001 : '0;
			if (next_rd_st == RD_PIX && rd_st == RD_PIX) begin
				col_index <= col_index + 16'h0001;
			end else begin
				col_index <= '0;
			end
			// one line at a time, next line when a pixel phase ends in a row overhead
			if (rd_st == RD_FOT) begin
				row_index <= '0;
			end else if (rd_st == RD_PIX && next_rd_st == RD_ROT) begin
				row_index <= row_index + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !seq_run) begin
			image_period_flag <= 1'b0;
			row_data_qualifier <= 1'b0;
			pixel_data <= '0;
		end else if (tick) begin
			image_period_flag <= next_rd_st == RD_ROT ||
				next_rd_st == RD_PIX;
			// pixel phase lies inside the flagged frame
			row_data_qualifier <= (next_rd_st == RD_PIX);
			pixel_data <= (next_rd_st == RD_PIX) ? converter_data : '0;
		end
	end
endmodule
`default_nettype wire

// *** verification/gsr_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module gsr_chk import gsr_pkg::*; #(
	parameter int PIX_W = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// watched ports
	input wire logic sequencer_reset_low,
	input wire logic [2:0] exposure_window_out,
	input wire logic [2:0] exposure_window_oe,
	input wire logic array_reset,
	input wire logic array_transfer,
	input wire logic [PIX_W-1:0] pixel_data,
	input wire logic row_data_qualifier,
	input wire logic image_period_flag
);
	// one tick of slack: the flag may rise on either side of the tick edge
	localparam int FOT_MIN = (FOT_TICKS - 1) * SEQ_DIV;
	logic [15:0] low_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !sequencer_reset_low);
	always_ff @(posedge clk) begin
		if (!rst_n || image_period_flag)
			low_cnt <= '0;
		else if (low_cnt != 16'hffff)
			low_cnt <= low_cnt + 16'h1;
	end
	sequence one_tick(sig);
		sig [*4] ##1 !sig;
	endsequence
	qual_in_frame_a: assert property (
		row_data_qualifier |-> image_period_flag)
		else $error("qualifier outside frame");
	pix_quiet_a: assert property (
		!row_data_qualifier |-> pixel_data == '0)
		else $error("pixel data outside pixel phase");
	seq_hold_a: assert property (disable iff (!rst_n)
		!sequencer_reset_low [*4] |-> !image_period_flag &&
		!row_data_qualifier && !array_reset && !array_transfer)
		else $error("sequencer runs while held");
	oe_mode_a: assert property (
		exposure_window_oe == 3'b000 || exposure_window_oe == 3'b111)
		else $error("window direction mixed");
	ext_quiet_a: assert property (
		exposure_window_oe == 3'b000 |-> exposure_window_out == 3'b000)
		else $error("window driven in external mode");
	reset_tick_a: assert property (
		$rose(array_reset) |-> one_tick(array_reset))
		else $error("array reset not one tick");
	xfer_tick_a: assert property (
		$rose(array_transfer) |-> one_tick(array_transfer))
		else $error("transfer not one tick");
	row_start_a: assert property (
		$rose(image_period_flag) |-> !row_data_qualifier [*8])
		else $error("no row overhead before pixels");
	dual_in_a: assert property (
		exposure_window_oe[1] && exposure_window_out[1] |->
		exposure_window_out[0])
		else $error("second window outside primary");
	triple_in_a: assert property (
		exposure_window_oe[2] && exposure_window_out[2] |->
		exposure_window_out[0])
		else $error("third window outside primary");
	fot_len_a: assert property (
		$rose(image_period_flag) |-> int'(low_cnt) >= FOT_MIN)
		else $error("frame overhead too short");
endmodule
bind gsr_readout_ctrl gsr_chk #(.PIX_W(PIX_W)) u_chk (
	.clk(clk),
	.rst_n(rst_n),
	.sequencer_reset_low(sequencer_reset_low),
	.exposure_window_out(exposure_window_out),
	.exposure_window_oe(exposure_window_oe),
	.array_reset(array_reset),
	.array_transfer(array_transfer),
	.pixel_data(pixel_data),
	.row_data_qualifier(row_data_qualifier),
	.image_period_flag(image_period_flag)
);
`default_nettype wire

// *** verification/gsr_cam_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module gsr_cam_model import gsr_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// exposure request
	input wire logic expose_go,
	// serial frame request: read flag, index, data
	input wire logic ser_go,
	input wire logic [20:0] ser_word,
	// pin drive
	output logic [2:0] window_drv,
	output logic serial_enable,
	output logic serial_clock,
	output logic serial_data
);
	logic [7:0] win_cnt;
	logic [20:0] ser_sh;
	logic [4:0] ser_bits;
	logic [3:0] ser_div;
	logic idle_tgl;
	always_ff @(posedge clk) begin
		if (!rst_n)
			win_cnt <= '0;
		else if (expose_go)
			win_cnt <= 8'h28;
		else if (win_cnt != 8'h00)
			win_cnt <= win_cnt - 8'h1;
	end
	// released line shows a changing level, not the last one
	always_ff @(posedge clk) begin
		idle_tgl <= !rst_n ? 1'b0 : !idle_tgl;
	end
	// data changes on the falling serial edge, 16 clk per bit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ser_sh <= '0;
			ser_bits <= 5'h00;
			ser_div <= 4'h0;
			serial_enable <= 1'b0;
			serial_clock <= 1'b0;
		end else if (ser_go) begin
			ser_sh <= ser_word;
			ser_bits <= 5'h15;
			ser_div <= 4'h0;
			serial_enable <= 1'b1;
		end else if (serial_enable) begin
			ser_div <= ser_div + 4'h1;
			if (ser_div == 4'h7)
				serial_clock <= 1'b1;
			if (ser_div == 4'hf) begin
				serial_clock <= 1'b0;
				ser_sh <= {ser_sh[19:0], 1'b0};
				ser_bits <= ser_bits - 5'h01;
				serial_enable <= (ser_bits != 5'h01);
			end
		end
	end
	assign serial_data = serial_enable ? ser_sh[20] : idle_tgl;
	// extra windows close together with the primary one
	assign window_drv[0] = win_cnt != 8'h00;
	assign window_drv[1] = window_drv[0] && win_cnt <= 8'h10;
	assign window_drv[2] = window_drv[0] && win_cnt <= 8'h08;
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench import gsr_pkg::*; ;
	localparam int LINES = 2;
	localparam int PIXELS = 4;
	localparam int WIN = 32;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [AW-1:0] reg_addr = '0;
	logic [DW-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sequencer_reset_low = 1'b1;
	logic [9:0] converter_data = '0;
	logic expose_go = 1'b0;
	logic ser_go = 1'b0;
	logic [20:0] ser_word = '0;
	int oe_seen = 0;
	logic [31:0] lfsr = 32'hf6af6242;
	logic [DW-1:0] reg_rdata, row_index, col_index;
	logic [2:0] ew_out, ew_oe, ew_drv, ew_pad, array_window;
	logic ser_en, ser_clk, ser_data, line_out, line_oe, line_pad;
	logic array_reset, array_transfer, qual, flag, rd_d, ar_d;
	logic [9:0] pixel_data;
	int error_cnt = 0;
	int checks = 0;
	int cycles = 0;
	int rst_seen, win_exp, qlen, flen, wlen;
	logic [DW-1:0] rd_q[$];
	int qual_q[$];
	int frame_q[$];
	logic [AW-1:0] addrs[7] = '{REG_CTRL, REG_LINES, REG_PIXELS,
		REG_INTEG, REG_DUAL, REG_TRIPLE, 8'h1c};
	logic [DW-1:0] rst_vals[7] = '{CTRL_RESET, LINES_RESET, PIXELS_RESET,
		INTEG_RESET, DUAL_RESET, TRIPLE_RESET, 16'h0000};
	logic [DW-1:0] new_vals[7] = '{16'h0000, 16'h0002, 16'h0004, 16'h0008,
		16'h0004, 16'h0002, 16'h0000};
	always #2.5 clk = ~clk;
	assign ew_pad = (ew_oe & ew_out) | (~ew_oe & ew_drv);
	assign line_pad = line_oe ? line_out : ser_data;
	gsr_readout_ctrl u_dut (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sequencer_reset_low(sequencer_reset_low),
		.exposure_window_in(ew_pad), .exposure_window_out(ew_out),
		.exposure_window_oe(ew_oe), .serial_port_enable(ser_en),
		.serial_port_clock(ser_clk), .serial_port_line_in(line_pad),
		.serial_port_line_out(line_out), .serial_port_line_oe(line_oe),
		.array_reset(array_reset), .array_transfer(array_transfer),
		.array_window(array_window), .row_index(row_index),
		.col_index(col_index), .converter_data(converter_data),
		.pixel_data(pixel_data), .row_data_qualifier(qual),
		.image_period_flag(flag)
	);
	gsr_cam_model u_cam (
		.clk(clk), .rst_n(rst_n), .expose_go(expose_go),
		.ser_go(ser_go), .ser_word(ser_word),
		.window_drv(ew_drv), .serial_enable(ser_en),
		.serial_clock(ser_clk), .serial_data(ser_data)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic bus(input logic w, input logic r, input logic [AW-1:0] a,
		input logic [DW-1:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask
	task automatic run_frames(input logic [DW-1:0] ctrl, input int n,
		input int win);
		for (int f = 0; f < n; f++) begin
			frame_q.push_back(LINES * (ROT_TICKS + PIXELS) * SEQ_DIV);
			for (int l = 0; l < LINES; l++)
				qual_q.push_back(PIXELS * SEQ_DIV);
		end
		win_exp = win;
		rst_seen = 0;
		bus(1'b1, 1'b0, REG_CTRL, ctrl);
		expose_go <= !ctrl[CTRL_INTERNAL];
		bus(1'b0, 1'b0, REG_CTRL, ctrl);
		expose_go <= 1'b0;
		while (frame_q.size() != 0)
			@(posedge clk);
		check(ew_oe, ctrl[CTRL_INTERNAL] ? 3'b111 : 3'b000);
		win_exp = 0;
		// stop the run while held so the next mode latches from idle
		sequencer_reset_low <= 1'b0;
		bus(1'b1, 1'b0, REG_CTRL, ctrl & 16'hffdf);
		bus(1'b0, 1'b0, REG_CTRL, ctrl);
		repeat (6) @(posedge clk);
		sequencer_reset_low <= 1'b1;
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		converter_data <= lfsr[9:0];
		lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			close_out();
		end
	end
	always @(negedge clk) begin
		if (rd_d)
			check(reg_rdata, rd_q.pop_front());
		rd_d = reg_rd;
		if (line_oe)
			oe_seen++;
		if (array_reset && !ar_d)
			rst_seen++;
		ar_d = array_reset;
		if (qual) begin
			qlen++;
		end else if (qlen != 0) begin
			check(qlen, qual_q.pop_front());
			qlen = 0;
		end
		if (flag) begin
			flen++;
		end else if (flen != 0) begin
			check(flen, frame_q.pop_front());
			flen = 0;
		end
		if (ew_oe[0] && ew_out[0]) begin
			wlen++;
		end else if (wlen != 0) begin
			if (win_exp != 0)
				check(wlen, win_exp);
			wlen = 0;
		end
	end
	initial begin
		{rd_d, ar_d, qlen, flen, wlen, win_exp} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (addrs[i]) begin
			rd_q.push_back(rst_vals[i]);
			bus(1'b0, 1'b1, addrs[i], '0);
		end
		for (int i = 1; i < 7; i++) begin
			bus(1'b1, 1'b0, addrs[i], i == 6 ? 16'hffff : new_vals[i]);
			rd_q.push_back(new_vals[i]);
			bus(1'b0, 1'b1, addrs[i], '0);
		end
		bus(1'b0, 1'b0, '0, '0);
		// serial write of the third window length, read back on the port
		ser_word <= {1'b0, 4'h5, 16'h0003};
		ser_go <= 1'b1;
		@(posedge clk);
		ser_go <= 1'b0;
		repeat (400) @(posedge clk);
		rd_q.push_back(16'h0003);
		bus(1'b0, 1'b1, REG_TRIPLE, '0);
		bus(1'b0, 1'b0, '0, '0);
		check(oe_seen, 0);
		run_frames(16'h0039, 1, WIN);
		run_frames(16'h003b, 2, WIN);
		run_frames(16'h0038, 1, 0);
		run_frames(16'h0025, 2, 0);
		bus(1'b1, 1'b0, REG_CTRL, 16'h0001);
		bus(1'b0, 1'b0, '0, '0);
		check(rst_seen, 1);
		check(qual_q.size(), 0);
		close_out();
	end
endmodule
`default_nettype wire
